/* File: shared/facp_consts.svh */
// Framing characters, address limits and serial configuration constants
// for the framed ASCII command parser. Definitions only.
`ifndef FACP_CONSTS_SVH
`define FACP_CONSTS_SVH

`define FACP_CH_SOF 8'h02
`define FACP_CH_ETX 8'h03
`define FACP_CH_CR 8'h0D
`define FACP_CH_SP 8'h20
`define FACP_CH_ZERO 8'h30
`define FACP_BCC_SEED 8'h00
`define FACP_ADDR_MAX 8'h7F
`define FACP_ADDR_UNSUP_LO 8'h80
`define FACP_ADDR_UNSUP_HI 8'hF7
`define FACP_ADDR_DIGITS 2'd3
`define FACP_BCC_DIGITS 2'd2
`define FACP_MAX_BODY 4'd8

`define FACP_CLK_HZ 100000000
`define FACP_BAUD_MIN 1200
`define FACP_BAUD_MAX 115200
`define FACP_BAUD_DEF 9600
`define FACP_BAUD_DIV_DEF 17'd10416
`define FACP_NET_PORT 16'd9882
`define FACP_NET_MAX_CONN 2'd3
`define FACP_MEAS_COUNT_DEF 8'h02

`endif

/* File: shared/facp_pkg.sv */
// Types shared by the command parser and its frame checker.
// Constants live in facp_consts.svh.
package facp_pkg;

    typedef enum logic [2:0] {
        FACP_IDLE = 3'b000,
        FACP_CMD1 = 3'b001,
        FACP_CMD2 = 3'b010,
        FACP_BODY = 3'b011,
        FACP_BCCH = 3'b100,
        FACP_BCCL = 3'b101,
        FACP_DONE = 3'b110
    } facp_state_t;

    typedef enum logic [1:0] {
        FACP_CMD_NONE = 2'b00,
        FACP_CMD_MODE = 2'b01,
        FACP_CMD_QUERY = 2'b10
    } facp_cmd_t;

    typedef enum logic [1:0] {
        FACP_GAS_SAMPLE = 2'b00,
        FACP_GAS_ZERO = 2'b01,
        FACP_GAS_SPAN = 2'b10
    } facp_gas_t;

    typedef enum logic [1:0] {
        FACP_PAR_NONE = 2'b00,
        FACP_PAR_ODD = 2'b01,
        FACP_PAR_EVEN = 2'b10
    } facp_parity_t;

endpackage : facp_pkg

/* File: src/facp_body_check.sv */
// Body layout checker: given the characters stored between the command
// letters and the terminator, decides whether the layout is acceptable
// and whether the address matches. Purely combinational.
// Assumes the caller holds up to eight body characters, oldest first.
`timescale 1ns/10ps
`default_nettype none
`include "facp_consts.svh"

module facp_body_check (
    input wire logic isMode,
    input wire logic [3:0] bodyLen,
    input wire logic [63:0] body,
    input wire logic [7:0] instAddr,
    output logic layoutOk,
    output facp_pkg::facp_gas_t gas
);
    function automatic logic isDigit(input logic [7:0] c);
        return c >= 8'h30 && c <= 8'h39;
    endfunction : isDigit

    function automatic logic [7:0] ch(input logic [63:0] b,
                                      input logic [3:0] i);
        return b[(i[2:0] * 8) +: 8];
    endfunction : ch

    // Three-character field padded with zeros or spaces
    function automatic logic addrOk(input logic [63:0] b,
                                    input logic [7:0] want);
        logic [9:0] val;
        logic seenDigit;
        logic ok;
        val = 10'd0;
        seenDigit = 1'b0;
        ok = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (ch(b, 4'(i)) == `FACP_CH_SP && !seenDigit) begin
                ok = ok;
            end else if (isDigit(ch(b, 4'(i)))) begin
                seenDigit = 1'b1;
                val = 10'(val * 10'd10 + {6'd0, ch(b, 4'(i)) - `FACP_CH_ZERO});
            end else begin
                ok = 1'b0;
            end
        end
        // Values 128..247 are never a valid address
        return ok && seenDigit && val <= {2'd0, `FACP_ADDR_MAX}
            && val == {2'd0, want};
    endfunction : addrOk

    function automatic logic isLetter(input logic [7:0] c);
        return c == 8'h4E || c == 8'h4B || c == 8'h4D;
    endfunction : isLetter

    logic [7:0] last;
    logic [3:0] spaces;

    always_comb begin
        last = ch(body, 4'(bodyLen - 4'd1));
        spaces = 4'd0;
        for (int i = 3; i < 8; i++) begin
            if (4'(i) < bodyLen && ch(body, 4'(i)) == `FACP_CH_SP) begin
                spaces = 4'(spaces + 4'd1);
            end
        end
        layoutOk = 1'b0;
        if (isMode) begin
            // Letter alone, space+letter, address+letter, address+space+letter
            if (bodyLen == 4'd1) begin
                layoutOk = isLetter(last);
            end else if (bodyLen == 4'd2) begin
                layoutOk = isLetter(last) && ch(body, 4'd0) == `FACP_CH_SP;
            end else if (bodyLen >= 4'd4) begin
                layoutOk = isLetter(last) && addrOk(body, instAddr)
                    && spaces == 4'(bodyLen - 4'd4);
            end
        end else begin
            // No address: nothing at all, not even a space
            if (bodyLen == 4'd0) begin
                layoutOk = 1'b1;
            end else if (bodyLen >= 4'd3) begin
                layoutOk = addrOk(body, instAddr)
                    && spaces == 4'(bodyLen - 4'd3);
            end
        end
        unique case (last)
            8'h4E: gas = facp_pkg::FACP_GAS_ZERO;
            8'h4B: gas = facp_pkg::FACP_GAS_SPAN;
            default: gas = facp_pkg::FACP_GAS_SAMPLE;
        endcase
    end
endmodule : facp_body_check

`default_nettype wire

/* File: src/framed_ascii_command_parser.sv */
// Framed ASCII command parser: takes received characters from a serial
// or network channel, checks framing, address and block check pair, and
// switches gas mode or requests a measurement reply.
// Assumes the byte source (UART or TCP) delivers one byte per rxValid
// pulse on ref_clk; the reply formatter is outside this block.
//
// Function
// - Serial port offers 7/8 data bits, 1/2 stops, none/odd/even parity.
// - Baud selectable 1200 to 115200, default 9600.
// - Network path uses TCP port 9882, up to three connections.
// - Address 0..127 as three ASCII chars, zero or space padded.
// - Addresses 128 through 247 are not supported.
// - Start-of-frame is 0x02, end-of-text is 0x03.
// - Carriage return is 0x0D, space is 0x20.
// - Frame opens with start byte, ends with end-of-text or return.
// - End-of-text brings two check characters; return brings none.
// - Check is XOR from seed 0x00 over all chars incl. framing.
// - Check sent as two hex digits, high nibble first.
// - Only mode-switch and data-query commands are recognised.
// - N selects zero, K span, M sample mode.
// - Mode switch only when not in service and option fitted.
// - Mode switch: optional address, optional space, either terminator.
// - Bad layout or wrong address discards the frame silently.
// - Valid query starts a measurement reply.
// - Query without address holds no spaces; still valid.
// - Query address must match; trailing spaces tolerated.
// - Reply ends with same terminator style as the command.
// - Reply header carries two-digit measurement count.
`timescale 1ns/10ps
`default_nettype none
`include "facp_consts.svh"

module framed_ascii_command_parser (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic [1:0] rxConn,
    input wire logic [7:0] instAddr,
    input wire logic serviceMode,
    input wire logic zeroSpanFitted,
    input wire logic [7:0] measCount,
    input wire logic cfgDataBits8,
    input wire logic cfgStopBits2,
    input wire logic [1:0] cfgParity,
    input wire logic [16:0] cfgBaud,
    output logic [1:0] gasMode,
    output logic gasModeStrobe,
    output logic replyStart,
    output logic replyWithCheck,
    output logic [1:0] replyConn,
    output logic [7:0] replyCountHi,
    output logic [7:0] replyCountLo,
    output logic serDataBits8,
    output logic serStopBits2,
    output logic [1:0] serParity,
    output logic [16:0] serBaudDiv,
    output logic [15:0] netPort,
    output logic [1:0] netMaxConn
);
    facp_pkg::facp_state_t state;
    facp_pkg::facp_cmd_t cmd;
    logic [7:0] bcc;
    logic [7:0] rxCheck;
    logic [63:0] body;
    logic [3:0] bodyLen;
    logic withCheck;
    logic layoutOk;
    facp_pkg::facp_gas_t gasSel;

    function automatic logic [3:0] hexVal(input logic [7:0] c,
                                          output logic ok);
        ok = 1'b1;
        if (c >= 8'h30 && c <= 8'h39) begin
            return 4'(c - 8'h30);
        end else if (c >= 8'h41 && c <= 8'h46) begin
            return 4'(c - 8'h37);
        end else if (c >= 8'h61 && c <= 8'h66) begin
            return 4'(c - 8'h57);
        end
        ok = 1'b0;
        return 4'h0;
    endfunction : hexVal

    function automatic logic [7:0] asciiDigit(input logic [3:0] d);
        return 8'(`FACP_CH_ZERO + {4'd0, d});
    endfunction : asciiDigit

    facp_body_check u_body_check (
        .isMode(cmd == facp_pkg::FACP_CMD_MODE),
        .bodyLen(bodyLen),
        .body(body),
        .instAddr(instAddr),
        .layoutOk(layoutOk),
        .gas(gasSel)
    );

    logic hexOk;
    logic [3:0] nib;
    always_comb begin
        nib = hexVal(rxData, hexOk);
    end

    logic frameEnd;
    logic frameGood;
    // A frame completes at a return, or at the second check digit
    always_comb begin
        frameEnd = 1'b0;
        frameGood = 1'b0;
        if (rxValid && rxData != `FACP_CH_SOF) begin
            if (state == facp_pkg::FACP_BODY && rxData == `FACP_CH_CR) begin
                frameEnd = 1'b1;
                frameGood = layoutOk;
            end else if (state == facp_pkg::FACP_BCCL) begin
                frameEnd = 1'b1;
                // High digit first, then low digit
                frameGood = layoutOk && hexOk
                    && {rxCheck[3:0], nib} == bcc;
            end
        end
    end

    // Frame state machine
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= facp_pkg::FACP_IDLE;
            cmd <= facp_pkg::FACP_CMD_NONE;
            bodyLen <= 4'd0;
            body <= 64'h0000_0000_0000_0000;
            withCheck <= 1'b0;
            rxCheck <= 8'h00;
        end else if (rxValid) begin
            if (rxData == `FACP_CH_SOF) begin
                state <= facp_pkg::FACP_CMD1;
                bodyLen <= 4'd0;
                cmd <= facp_pkg::FACP_CMD_NONE;
            end else begin
                unique case (state)
                    facp_pkg::FACP_IDLE, facp_pkg::FACP_DONE: begin
                        state <= facp_pkg::FACP_IDLE;
                    end
                    facp_pkg::FACP_CMD1: begin
                        if (rxData == 8'h53) begin
                            cmd <= facp_pkg::FACP_CMD_MODE;
                            state <= facp_pkg::FACP_CMD2;
                        end else if (rxData == 8'h44) begin
                            cmd <= facp_pkg::FACP_CMD_QUERY;
                            state <= facp_pkg::FACP_CMD2;
                        end else begin
                            state <= facp_pkg::FACP_IDLE;
                        end
                    end
                    facp_pkg::FACP_CMD2: begin
                        if ((cmd == facp_pkg::FACP_CMD_MODE && rxData == 8'h54)
                            || (cmd == facp_pkg::FACP_CMD_QUERY
                                && rxData == 8'h41)) begin
                            state <= facp_pkg::FACP_BODY;
                        end else begin
                            state <= facp_pkg::FACP_IDLE;
                        end
                    end
                    facp_pkg::FACP_BODY: begin
                        if (rxData == `FACP_CH_CR) begin
                            withCheck <= 1'b0;
                            state <= facp_pkg::FACP_DONE;
                        end else if (rxData == `FACP_CH_ETX) begin
                            withCheck <= 1'b1;
                            state <= facp_pkg::FACP_BCCH;
                        end else if (bodyLen == `FACP_MAX_BODY) begin
                            state <= facp_pkg::FACP_IDLE;
                        end else begin
                            body[(bodyLen[2:0] * 8) +: 8] <= rxData;
                            bodyLen <= 4'(bodyLen + 4'd1);
                        end
                    end
                    facp_pkg::FACP_BCCH: begin
                        rxCheck <= {4'h0, nib};
                        state <= hexOk ? facp_pkg::FACP_BCCL
                                       : facp_pkg::FACP_IDLE;
                    end
                    facp_pkg::FACP_BCCL: begin
                        state <= facp_pkg::FACP_DONE;
                    end
                endcase
            end
        end
    end

    // Running XOR; the start byte itself seeds it from zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bcc <= `FACP_BCC_SEED;
        end else if (rxValid) begin
            if (rxData == `FACP_CH_SOF) begin
                bcc <= `FACP_BCC_SEED ^ rxData;
            end else if (state == facp_pkg::FACP_CMD1
                         || state == facp_pkg::FACP_CMD2
                         || state == facp_pkg::FACP_BODY) begin
                bcc <= bcc ^ rxData;
            end
        end
    end

    // Gas mode actions
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gasMode <= facp_pkg::FACP_GAS_SAMPLE;
            gasModeStrobe <= 1'b0;
        end else begin
            gasModeStrobe <= 1'b0;
            if (frameEnd && frameGood && cmd == facp_pkg::FACP_CMD_MODE
                && !serviceMode && zeroSpanFitted) begin
                gasMode <= gasSel;
                gasModeStrobe <= 1'b1;
            end
        end
    end

    // Reply request to the formatter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            replyStart <= 1'b0;
            replyWithCheck <= 1'b0;
            replyConn <= 2'd0;
            replyCountHi <= `FACP_CH_ZERO;
            replyCountLo <= `FACP_CH_ZERO;
        end else begin
            replyStart <= 1'b0;
            if (frameEnd && frameGood && cmd == facp_pkg::FACP_CMD_QUERY) begin
                replyStart <= 1'b1;
                replyWithCheck <= state == facp_pkg::FACP_BCCL;
                replyConn <= rxConn;
                // Counts above 99 are clipped to two digits
                replyCountHi <= asciiDigit(4'((measCount > 8'd99
                    ? 8'd99 : measCount) / 8'd10));
                replyCountLo <= asciiDigit(4'((measCount > 8'd99
                    ? 8'd99 : measCount) % 8'd10));
            end
        end
    end

    // Serial and network settings handed to the physical layers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            serDataBits8 <= 1'b1;
            serStopBits2 <= 1'b0;
            serParity <= facp_pkg::FACP_PAR_NONE;
            serBaudDiv <= `FACP_BAUD_DIV_DEF;
            netPort <= `FACP_NET_PORT;
            netMaxConn <= `FACP_NET_MAX_CONN;
        end else begin
            serDataBits8 <= cfgDataBits8;
            serStopBits2 <= cfgStopBits2;
            serParity <= cfgParity == 2'b11 ? facp_pkg::FACP_PAR_NONE
                                            : cfgParity;
            // Out-of-range rates keep the last valid divider
            if (cfgBaud >= 17'(`FACP_BAUD_MIN)
                && cfgBaud <= 17'(`FACP_BAUD_MAX)) begin
                // 17 bits so the slowest rate (divider 83333) still fits
                serBaudDiv <= 17'(32'(`FACP_CLK_HZ) / 32'(cfgBaud));
            end
        end
    end
endmodule : framed_ascii_command_parser

`default_nettype wire

/* File: bench/facp_host_model.sv */
// Host model: sends framed command strings to the parser, one byte a cycle.
// Assumes a free-running ref_clk; the testbench calls its tasks.
`timescale 1ns/10ps
`default_nettype none

module facp_host_model (
    input wire logic ref_clk,
    output logic rxValid,
    output logic [7:0] rxData
);
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
    end

    function automatic logic [7:0] hex_char(input logic [3:0] n, input bit lc);
        if (n < 4'hA) begin
            return 8'h30 + {4'h0, n};
        end
        return (lc ? 8'h57 : 8'h37) + {4'h0, n};
    endfunction : hex_char

    task automatic put(input logic [7:0] b);
        @(posedge ref_clk);
        rxValid <= 1'b1;
        rxData <= b;
    endtask : put

    // Released line shows the inverse, so a stale byte never looks valid
    task automatic idle();
        @(posedge ref_clk);
        rxValid <= 1'b0;
        rxData <= ~rxData;
    endtask : idle

    // Spoil is XORed into the check pair to send a corrupt one on purpose
    task automatic send_frame(input string body, input bit etx,
                              input logic [7:0] spoil, input bit lc);
        logic [7:0] sum;
        sum = 8'h00;
        put(8'h02);
        sum = sum ^ 8'h02;
        foreach (body[i]) begin
            put(body[i]);
            sum = sum ^ body[i];
        end
        if (etx) begin
            put(8'h03);
            sum = sum ^ 8'h03 ^ spoil;
            put(hex_char(sum[7:4], lc));
            put(hex_char(sum[3:0], lc));
        end else begin
            put(8'h0D);
        end
        idle();
    endtask : send_frame
endmodule : facp_host_model
`default_nettype wire

/* File: bench/facp_parser_checker.sv */
// Concurrent checks on the command parser's ports.
// Bound into every parser instance; sees only top-level ports.
`timescale 1ns/10ps
`default_nettype none

module facp_parser_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic serviceMode,
    input wire logic zeroSpanFitted,
    input wire logic [7:0] measCount,
    input wire logic [1:0] gasMode,
    input wire logic gasModeStrobe,
    input wire logic replyStart,
    input wire logic replyWithCheck,
    input wire logic [7:0] replyCountHi,
    input wire logic [7:0] replyCountLo,
    input wire logic [15:0] netPort,
    input wire logic [1:0] netMaxConn
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    logic [7:0] clipCount;
    assign clipCount = (measCount > 8'h63) ? 8'h63 : measCount;

    a_mode_needs_unlock: assert property (
        gasModeStrobe |-> $past(rxValid) && !$past(serviceMode)
            && $past(zeroSpanFitted))
        else $error("mode switch without final byte or while locked");
    a_mode_end_byte: assert property (
        gasModeStrobe |-> $past(rxData) != 8'h02 && $past(rxData) != 8'h03)
        else $error("mode switch right after a framing byte");
    a_mode_pulse: assert property (
        gasModeStrobe |=> !gasModeStrobe && !replyStart)
        else $error("mode strobe longer than one cycle");
    a_mode_change: assert property (
        !$stable(gasMode) |-> gasModeStrobe && gasMode != 2'b11)
        else $error("gas mode moved without strobe or to illegal code");
    a_reply_end_byte: assert property (
        replyStart |-> $past(rxValid) && $past(rxData) != 8'h02
            && $past(rxData) != 8'h03 && !gasModeStrobe)
        else $error("reply started without a proper final byte");
    a_reply_pulse: assert property (
        replyStart |=> !replyStart)
        else $error("reply start longer than one cycle");
    a_reply_term: assert property (
        replyStart |-> replyWithCheck == ($past(rxData) != 8'h0D))
        else $error("reply terminator style differs from command");
    a_count_digits: assert property (
        replyStart && $stable(measCount) |->
            replyCountHi == 8'h30 + clipCount / 8'h0A
            && replyCountLo == 8'h30 + clipCount % 8'h0A)
        else $error("reply count digits wrong");
    a_net_fixed: assert property (
        netPort == 16'h269A && netMaxConn == 2'h3)
        else $error("network settings wrong");
endmodule : facp_parser_checker

bind framed_ascii_command_parser facp_parser_checker chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .rxValid(rxValid), .rxData(rxData),
    .serviceMode(serviceMode), .zeroSpanFitted(zeroSpanFitted),
    .measCount(measCount), .gasMode(gasMode), .gasModeStrobe(gasModeStrobe),
    .replyStart(replyStart), .replyWithCheck(replyWithCheck),
    .replyCountHi(replyCountHi), .replyCountLo(replyCountLo),
    .netPort(netPort), .netMaxConn(netMaxConn)
);
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the command parser, host model on the rx side.
// Assumes one 100 MHz clock; expectations come from bench functions.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic ref_clk, arst_n, rxValid, serviceMode, zeroSpanFitted;
    logic [7:0] rxData, instAddr, measCount, replyCountHi, replyCountLo;
    logic [1:0] rxConn, cfgParity, gasMode, replyConn, serParity, netMaxConn;
    logic cfgDataBits8, cfgStopBits2, gasModeStrobe, replyStart;
    logic replyWithCheck, serDataBits8, serStopBits2;
    logic [16:0] cfgBaud;
    logic [15:0] netPort;
    logic [16:0] serBaudDiv, expDiv;
    integer errors = 0, cmp_count = 0, seed = 99, cycles = 0;
    integer nMode = 0, nReply = 0;
    logic [16:0] corners [5] = '{17'h1_C200, 17'h0_2580, 17'h0_04AF,
                                 17'h1_C201, 17'h0_04B0};
    string letters = "NKM";
    string body;

    framed_ascii_command_parser DUT (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rxValid(rxValid),
        .rxData(rxData),
        .rxConn(rxConn),
        .instAddr(instAddr),
        .serviceMode(serviceMode),
        .zeroSpanFitted(zeroSpanFitted),
        .measCount(measCount),
        .cfgDataBits8(cfgDataBits8),
        .cfgStopBits2(cfgStopBits2),
        .cfgParity(cfgParity),
        .cfgBaud(cfgBaud),
        .gasMode(gasMode),
        .gasModeStrobe(gasModeStrobe),
        .replyStart(replyStart),
        .replyWithCheck(replyWithCheck),
        .replyConn(replyConn),
        .replyCountHi(replyCountHi),
        .replyCountLo(replyCountLo),
        .serDataBits8(serDataBits8),
        .serStopBits2(serStopBits2),
        .serParity(serParity),
        .serBaudDiv(serBaudDiv),
        .netPort(netPort),
        .netMaxConn(netMaxConn)
    );
    facp_host_model host (.ref_clk(ref_clk), .rxValid(rxValid), .rxData(rxData));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (gasModeStrobe === 1'b1) nMode <= nMode + 1;
        if (replyStart === 1'b1) nReply <= nReply + 1;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end

    function automatic logic [1:0] exp_gas(input logic [7:0] c);
        return (c == "N") ? 2'h1 : ((c == "K") ? 2'h2 : 2'h0);
    endfunction : exp_gas

    function automatic logic [15:0] exp_count(input logic [7:0] m);
        logic [7:0] c;
        c = (m > 8'h63) ? 8'h63 : m;
        return {8'h30 + c / 8'h0A, 8'h30 + c % 8'h0A};
    endfunction : exp_count

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One frame, then count mode switches and replies that followed it
    task automatic run_frame(input string b, input bit etx,
                             input logic [7:0] spoil, input int m, input int r);
        int m0;
        int r0;
        m0 = nMode;
        r0 = nReply;
        host.send_frame(b, etx, spoil, $random(seed) & 1);
        repeat (4) @(posedge ref_clk);
        check(nMode - m0, m);
        check(nReply - r0, r);
    endtask : run_frame

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        arst_n = 1'b0;
        rxConn = 2'h0;
        instAddr = 8'h05;
        serviceMode = 1'b0;
        zeroSpanFitted = 1'b1;
        measCount = 8'h02;
        cfgDataBits8 = 1'b1;
        cfgStopBits2 = 1'b0;
        cfgParity = 2'h0;
        cfgBaud = 17'h0_2580;
        repeat (20) @(posedge ref_clk);
        check(serBaudDiv, 16'h28B0);
        check(gasMode, 2'h0);
        arst_n <= 1'b1;
        // Corners sit on both ends of the legal rate range, just outside them, and on the default 9600
        expDiv = 17'h0_28B0;
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            cfgBaud <= (i < 5) ? corners[i]
                : 17'h0_04B0 + 17'($unsigned($random(seed)) % 17'h1_BD51);
            cfgDataBits8 <= $random(seed);
            cfgStopBits2 <= $random(seed);
            cfgParity <= $random(seed);
            repeat (3) @(posedge ref_clk);
            if (cfgBaud >= 17'h0_04B0 && cfgBaud <= 17'h1_C200) begin
                expDiv = 17'(32'h05F5_E100 / cfgBaud);
            end
            check(serBaudDiv, expDiv);
            check(serDataBits8, cfgDataBits8);
            check(serStopBits2, cfgStopBits2);
            check(serParity, (cfgParity == 2'h3) ? 2'h0 : cfgParity);
        end
        check(netPort, 16'h269A);
        check(netMaxConn, 2'h3);
        $display("test serial settings finished");
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            measCount <= (i == 0) ? 8'h63 : ((i == 1) ? 8'h64 : $random(seed));
            rxConn <= $random(seed);
            run_frame("DA", i[0], 8'h00, 0, 1);
            check(replyWithCheck, i[0]);
            check({replyCountHi, replyCountLo}, exp_count(measCount));
            check(replyConn, rxConn);
        end
        run_frame("DA", 1, 8'h10, 0, 0);
        run_frame("DA005", 0, 8'h00, 0, 1);
        run_frame("DA  5   ", 1, 8'h00, 0, 1);
        run_frame("DA006", 1, 8'h00, 0, 0);
        run_frame("DA005      ", 0, 8'h00, 0, 0);
        run_frame("DA ", 0, 8'h00, 0, 0);
        run_frame("XY", 0, 8'h00, 0, 0);
        host.put(8'h02);
        host.put("S");
        run_frame("DA", 0, 8'h00, 0, 1);
        // An address of 200 must fail even when it is the configured one
        @(posedge ref_clk);
        instAddr <= 8'hC8;
        run_frame("DA200", 0, 8'h00, 0, 0);
        @(posedge ref_clk);
        instAddr <= 8'h48;
        run_frame("DA072", 1, 8'h00, 0, 1);
        @(posedge ref_clk);
        instAddr <= 8'h05;
        $display("test data query finished");
        for (int i = 0; i < 12; i++) begin
            body = "ST";
            if (i % 4 == 1) body = {body, "005"};
            if (i % 4 == 2) body = {body, "  5"};
            if (i % 4 == 3 || (i % 4 != 0 && ($random(seed) & 1))) body = {body, " "};
            body = {body, letters.substr(i % 3, i % 3)};
            run_frame(body, $random(seed) & 1, 8'h00, 1, 0);
            check(gasMode, exp_gas(letters[i % 3]));
        end
        run_frame("ST006N", 0, 8'h00, 0, 0);
        run_frame("STN", 1, 8'h01, 0, 0);
        @(posedge ref_clk);
        serviceMode <= 1'b1;
        run_frame("STK", 0, 8'h00, 0, 0);
        @(posedge ref_clk);
        serviceMode <= 1'b0;
        zeroSpanFitted <= 1'b0;
        run_frame("STK", 1, 8'h00, 0, 0);
        check(gasMode, 2'h0);
        $display("test mode switch finished");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
